//--- hw/time_pulse_pkg.sv
// Purpose: constants and carrier types for the time pulse generator
// Assumes: 20 MHz clock, Avalon-MM register slave with byte addresses
// Notes:   register offsets are byte addresses of 32-bit words
package time_pulse_pkg;
   localparam int unsigned CLK_HZ       = 20_000_000;
   localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
   localparam int unsigned PCT_FULL     = 100;
   localparam int unsigned MIN_PHASE_NS = 50;
   localparam int unsigned CLK_NS       = 1_000_000_000 / CLK_HZ;
   localparam int unsigned MIN_PHASE_CYC =
      (MIN_PHASE_NS + CLK_NS - 1) / CLK_NS;

   // register byte offsets
   localparam logic [7:0] UTC_CTRL_OFS  = 8'h00;
   localparam logic [7:0] EVT_CTRL_OFS  = 8'h04;
   localparam logic [7:0] EVT_RISE_OFS  = 8'h08;
   localparam logic [7:0] EVT_FALL_OFS  = 8'h0c;
   localparam logic [7:0] EVT_STAT_OFS  = 8'h10;
   localparam logic [7:0] CH_BASE_OFS   = 8'h20;
   localparam logic [7:0] CH_STRIDE     = 8'h20;
   localparam logic [4:0] CH_CTRL_OFS   = 5'h00;
   localparam logic [4:0] CH_RATEU_OFS  = 5'h04;
   localparam logic [4:0] CH_WIDTHU_OFS = 5'h08;
   localparam logic [4:0] CH_RATEL_OFS  = 5'h0c;
   localparam logic [4:0] CH_WIDTHL_OFS = 5'h10;
   localparam logic [4:0] CH_DELAY_OFS  = 5'h14;
   localparam logic [4:0] CH_STAT_OFS   = 5'h18;

   // time grids; index into the tick vector
   localparam logic [2:0] GRID_UTC   = 3'h0;
   localparam logic [2:0] GRID_GPS   = 3'h1;
   localparam logic [2:0] GRID_GLO   = 3'h2;
   localparam logic [2:0] GRID_BDS   = 3'h3;
   localparam logic [2:0] GRID_GAL   = 3'h4;
   localparam logic [2:0] GRID_LOCAL = 3'h5;
   localparam int unsigned NUM_REF   = 6;

   // constellation enable mask bits
   localparam int unsigned CON_GPS = 0;
   localparam int unsigned CON_GLO = 1;
   localparam int unsigned CON_BDS = 2;
   localparam int unsigned CON_GAL = 3;
   localparam int unsigned CON_NAV = 4;

   typedef enum logic [2:0] {
      UTC_AUTO, UTC_USNO, UTC_SU, UTC_NTSC, UTC_EU, UTC_NPLI
   } utc_variant_t;

   // rate type 0 = period, width type 0 = ratio
   typedef struct packed {
      logic [2:0] pulseGridSelect;
      logic       reserved;
      logic       freqLockEnable;
      logic       leadingEdgePolarity;
      logic       alternateSettingEnable;
      logic       secondAlignmentEnable;
      logic       widthTypeSelect;
      logic       rateTypeSelect;
      logic       pulseChannelEnable;
   } chan_ctrl_t;

   typedef struct packed {
      chan_ctrl_t  ctrl;
      logic [31:0] unlockedRateValue;
      logic [31:0] unlockedWidthValue;
      logic [31:0] lockedRateValue;
      logic [31:0] lockedWidthValue;
      logic [15:0] userDelay;
      logic [15:0] cableDelay;
   } chan_regs_t;

   localparam chan_ctrl_t CTRL_RESET = '0;
endpackage

//--- hw/gnss_time_pulse_generator.sv
// Purpose: pulse channels aligned to a time grid, plus event time marks
// Assumes: grid second ticks, lock and epoch strobes come from the time engine
// Notes:   delays are in clock cycles; stamps are cycles since grid second
//
// Contract
// R1: one satellite time and one UTC variant
// R2: new auto UTC order: EU, USNO, NTSC, NPLI
// R3: legacy auto order: USNO, SU, NTSC, EU, NPLI
// R4: input pulse aligned to output time base
// R5: UTC grid: input pulses aligned to GPS; with eventRefSelect at GRID_UTC stamps count from the UTC tick
// R6: UTC grid holds output until parameters received
// R7: output only while channel enabled
// R8: rate type selects frequency or period
// R9: width type selects microseconds or percent
// R10: positive cable delay advances pulse
// R11: locked values used once time valid
// R12: positive user delay retards pulse
// R13: frequency lock uses corrected tick
// R14: second alignment places pulses on seconds
// R15: alignment only while locked; rate continues
// R16: polarity set means rising leading edge
// R17: grid selects pulse and report time base
// R18: width clamped to period
// R19: host keeps both phases at least 50 ns
// R20: event stamps against selectable reference
// R21: delays also applied to event stamps
// R22: report at epoch if enabled and edge
// R23: only latest rise and fall kept
// R24: settings change only at pulse boundary; code defers rate, width and polarity to it, not enable or grid select
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module gnss_time_pulse_generator
   import time_pulse_pkg::*;
#(
   parameter int unsigned NCH = 2
) (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic [7:0]          address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   input  wire logic [3:0]          byteenable,
   output      logic [31:0]         readdata,
   output      logic                waitrequest,
   input  wire logic [NUM_REF-2:0]  gridSecondTick,
   input  wire logic                timeValid,
   input  wire logic                utcParamsValid,
   input  wire logic                correctedTick,
   input  wire logic                measEpoch,
   input  wire logic                eventInputPin,
   output      logic [NCH-1:0]      pulseOut,
   output      logic                eventReportStrobe,
   output      utc_variant_t        utcVariant
);

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic utc_variant_t resolveUtc(input utc_variant_t sel,
                                               input logic [4:0]   mask,
                                               input logic         legacy);
      utc_variant_t v;
      v = UTC_AUTO;
      if (sel != UTC_AUTO) begin
         v = sel;
      end else if (legacy) begin                                      // R3
         if (mask[CON_GPS])      v = UTC_USNO;
         else if (mask[CON_GLO]) v = UTC_SU;
         else if (mask[CON_BDS]) v = UTC_NTSC;
         else if (mask[CON_GAL]) v = UTC_EU;
         else if (mask[CON_NAV]) v = UTC_NPLI;
      end else begin                                                  // R2
         if (mask[CON_GAL])      v = UTC_EU;
         else if (mask[CON_GPS]) v = UTC_USNO;
         else if (mask[CON_BDS]) v = UTC_NTSC;
         else if (mask[CON_NAV]) v = UTC_NPLI;
      end
      return v;
   endfunction

   // ***********************************************************
   // registers and local time base
   // ***********************************************************
   chan_regs_t          chanRegs [NCH];
   utc_variant_t        utcVariantSelect;
   logic                legacyOrder;
   logic [4:0]          constMask;
   logic                reportEnable;
   logic [2:0]          eventRefSelect;
   logic [31:0]         riseStamp;
   logic [31:0]         fallStamp;
   logic [31:0]         riseReport;
   logic [31:0]         fallReport;
   logic                riseNew;
   logic                fallNew;
   logic [7:0]          markCount;
   logic [7:0]          reportCount;
   logic [1:0]          reportFlags;
   logic [31:0]         localCnt;
   logic                localTick;
   logic [NUM_REF-1:0]  refTick;
   logic [31:0]         chanSeconds [NCH];
   logic [NCH-1:0]      chanActive;
   logic                busHit;

   assign refTick = {localTick, gridSecondTick};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         localCnt  <= '0;
         localTick <= 1'b0;
      end else begin
         localTick <= (localCnt == 32'(CLK_HZ - 2));
         localCnt  <= (localCnt == 32'(CLK_HZ - 1)) ? '0 : localCnt + 32'd1;
      end
   end

   // ***********************************************************
   // Avalon-MM slave: one wait state, then the access completes
   // ***********************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   assign busHit = write && !waitrequest;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         utcVariantSelect <= UTC_AUTO;
         legacyOrder      <= 1'b0;
         constMask        <= '0;
         reportEnable     <= 1'b0;
         eventRefSelect   <= GRID_UTC;
         for (int c = 0; c < NCH; c++) begin
            chanRegs[c] <= '0;
         end
      end else if (busHit) begin
         if (address == UTC_CTRL_OFS && byteenable[0]) begin         // R1
            utcVariantSelect <= utc_variant_t'(writedata[2:0]);
            legacyOrder      <= writedata[3];
            constMask        <= {writedata[8], writedata[7:4]};
         end
         if (address == EVT_CTRL_OFS && byteenable[0]) begin
            reportEnable   <= writedata[0];
            eventRefSelect <= writedata[3:1];
         end
         for (int c = 0; c < NCH; c++) begin
            if (address[7:5] == 3'(c + 1)) begin
               case (address[4:0])
                  CH_CTRL_OFS: begin
                     if (byteenable[0]) chanRegs[c].ctrl[7:0] <= writedata[7:0];
                     if (byteenable[1]) chanRegs[c].ctrl[10:8] <= writedata[10:8];
                  end
                  CH_RATEU_OFS: chanRegs[c].unlockedRateValue <=
                     mergeBytes(chanRegs[c].unlockedRateValue, writedata, byteenable);
                  CH_WIDTHU_OFS: chanRegs[c].unlockedWidthValue <=
                     mergeBytes(chanRegs[c].unlockedWidthValue, writedata, byteenable);
                  CH_RATEL_OFS: chanRegs[c].lockedRateValue <=
                     mergeBytes(chanRegs[c].lockedRateValue, writedata, byteenable);
                  CH_WIDTHL_OFS: chanRegs[c].lockedWidthValue <=
                     mergeBytes(chanRegs[c].lockedWidthValue, writedata, byteenable);
                  CH_DELAY_OFS: {chanRegs[c].userDelay, chanRegs[c].cableDelay} <=
                     mergeBytes({chanRegs[c].userDelay, chanRegs[c].cableDelay},
                                writedata, byteenable);
                  default: ;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         readdata <= '0;
      end else if (read && waitrequest) begin
         readdata <= '0;
         case (address)
            UTC_CTRL_OFS: readdata <= {13'h0000, utcVariant, 7'h00, constMask,
                                       legacyOrder, utcVariantSelect};
            EVT_CTRL_OFS: readdata <= {22'h000000, utcParamsValid, timeValid,
                                       4'h0, eventRefSelect, reportEnable};
            EVT_RISE_OFS: readdata <= riseReport;
            EVT_FALL_OFS: readdata <= fallReport;
            EVT_STAT_OFS: readdata <= {16'h0000, reportCount, 6'h00, reportFlags};
            default: begin
               for (int c = 0; c < NCH; c++) begin
                  if (address[7:5] == 3'(c + 1)) begin
                     case (address[4:0])
                        CH_CTRL_OFS:   readdata <= {21'h000000, chanRegs[c].ctrl};
                        CH_RATEU_OFS:  readdata <= chanRegs[c].unlockedRateValue;
                        CH_WIDTHU_OFS: readdata <= chanRegs[c].unlockedWidthValue;
                        CH_RATEL_OFS:  readdata <= chanRegs[c].lockedRateValue;
                        CH_WIDTHL_OFS: readdata <= chanRegs[c].lockedWidthValue;
                        CH_DELAY_OFS:  readdata <= {chanRegs[c].userDelay,
                                                    chanRegs[c].cableDelay};
                        CH_STAT_OFS:   readdata <= {chanActive[c], chanSeconds[c][30:0]};
                        default:       readdata <= '0;
                     endcase
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         utcVariant <= UTC_AUTO;
      end else begin
         utcVariant <= resolveUtc(utcVariantSelect, constMask, legacyOrder); // R1
      end
   end

   // ***********************************************************
   // pulse channels
   // ***********************************************************
   for (genvar g = 0; g < NCH; g++) begin : gen_chan
      chan_ctrl_t         ctl;
      logic               useLocked;
      logic [31:0]        rateVal;
      logic [31:0]        widthVal;
      logic [31:0]        next_period;
      logic [31:0]        next_width;
      logic [63:0]        ratioProd;
      logic signed [17:0] phase;
      logic [31:0]        alignLoad;
      logic [31:0]        cnt;
      logic [31:0]        curPeriod;
      logic [31:0]        curWidth;
      logic               curPol;
      logic               step;
      logic               boundary;
      logic               alignNow;
      logic               heldOff;

      assign ctl       = chanRegs[g].ctrl;
      assign useLocked = ctl.alternateSettingEnable && timeValid;           // R11
      assign rateVal   = useLocked ? chanRegs[g].lockedRateValue
                                   : chanRegs[g].unlockedRateValue;
      assign widthVal  = useLocked ? chanRegs[g].lockedWidthValue
                                   : chanRegs[g].unlockedWidthValue;

      always_comb begin
         if (!ctl.rateTypeSelect) begin                                     // R8
            next_period = 32'(rateVal * CYC_PER_US);
         end else if (rateVal == '0) begin
            next_period = '0;
         end else begin
            next_period = 32'(CLK_HZ) / rateVal;
         end
      end

      assign ratioProd = 64'(next_period) * 64'(widthVal);

      always_comb begin
         if (ctl.widthTypeSelect) begin                                     // R9
            next_width = 32'(widthVal * CYC_PER_US);
         end else begin
            next_width = 32'(ratioProd / 64'(PCT_FULL));
         end
         if (next_width > next_period) begin                                // R18
            next_width = next_period;
         end
      end

      // cable advances, user retards
      assign phase = 18'(signed'(chanRegs[g].cableDelay))
                   - 18'(signed'(chanRegs[g].userDelay));                   // R10 R12
      assign alignLoad = (phase < 0) ? curPeriod + 32'(phase) : 32'(phase);
      assign step     = ctl.freqLockEnable ? correctedTick : 1'b1;          // R13
      assign boundary = step && (cnt + 32'd1 >= curPeriod);
      assign alignNow = ctl.secondAlignmentEnable && timeValid
                        && refTick[ctl.pulseGridSelect];                    // R14 R15 R17
      assign heldOff  = (ctl.pulseGridSelect == GRID_UTC) && !utcParamsValid; // R6

      always_ff @(posedge clk) begin
         if (!reset_n) begin
            cnt       <= '0;
            curPeriod <= '0;
            curWidth  <= '0;
            curPol    <= 1'b0;
         end else if (alignNow) begin
            cnt <= (alignLoad >= curPeriod) ? '0 : alignLoad;
         end else if (boundary || curPeriod == '0) begin                   // R24
            cnt       <= '0;
            curPeriod <= next_period;
            curWidth  <= next_width;
            curPol    <= ctl.leadingEdgePolarity;
         end else if (step) begin
            cnt <= cnt + 32'd1;
         end
      end

      always_ff @(posedge clk) begin
         if (!reset_n) begin
            pulseOut[g]   <= 1'b0;
            chanActive[g] <= 1'b0;
         end else begin
            chanActive[g] <= ctl.pulseChannelEnable && !heldOff
                             && curPeriod != '0 && cnt < curWidth;          // R7 R6
            pulseOut[g]   <= (ctl.pulseChannelEnable && !heldOff
                              && curPeriod != '0 && cnt < curWidth)
                             ? curPol : !curPol;                            // R16
         end
      end

      always_ff @(posedge clk) begin
         if (!reset_n) begin
            chanSeconds[g] <= '0;
         end else if (refTick[ctl.pulseGridSelect]) begin                  // R17
            chanSeconds[g] <= chanSeconds[g] + 32'd1;
         end
      end
   end

   // ***********************************************************
   // event time marks
   // ***********************************************************
   logic        evPrev;
   logic [31:0] evCnt;
   logic [31:0] evStamp;

   // stamp uses channel zero delays
   assign evStamp = evCnt + 32'(signed'(chanRegs[0].cableDelay))
                  - 32'(signed'(chanRegs[0].userDelay));                    // R21

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evCnt <= '0;
      end else if (refTick[eventRefSelect]) begin                          // R20
         evCnt <= '0;
      end else begin
         evCnt <= evCnt + 32'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evPrev    <= 1'b0;
         riseStamp <= '0;
         fallStamp <= '0;
         markCount <= '0;
      end else begin
         evPrev <= eventInputPin;
         if (eventInputPin && !evPrev) begin
            riseStamp <= evStamp;                                            // R23
            markCount <= markCount + 8'd1;
         end
         if (!eventInputPin && evPrev) begin
            fallStamp <= evStamp;                                            // R23
            markCount <= markCount + 8'd1;
         end
      end
   end

   // an edge in the epoch cycle stays pending for the next epoch
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         riseNew           <= 1'b0;
         fallNew           <= 1'b0;
         riseReport        <= '0;
         fallReport        <= '0;
         reportFlags       <= '0;
         reportCount       <= '0;
         eventReportStrobe <= 1'b0;
      end else begin
         eventReportStrobe <= 1'b0;
         if (measEpoch && reportEnable && (riseNew || fallNew)) begin       // R22
            riseReport        <= riseStamp;
            fallReport        <= fallStamp;
            reportFlags       <= {fallNew, riseNew};
            reportCount       <= markCount;
            eventReportStrobe <= 1'b1;
         end
         riseNew <= (eventInputPin && !evPrev)
                    || (riseNew && !measEpoch);
         fallNew <= (!eventInputPin && evPrev)
                    || (fallNew && !measEpoch);
      end
   end

endmodule

//--- bench/gnss_time_pulse_chk.sv
// Purpose: port-level assertions for the time pulse generator
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the top module, sees its ports only
`timescale 1ns/1ps
module gnss_time_pulse_chk
   import time_pulse_pkg::*;
#(
   parameter int unsigned NCH = 2
) (
   input wire logic               clk,
   input wire logic               reset_n,
   input wire logic [7:0]         address,
   input wire logic               read,
   input wire logic               write,
   input wire logic [31:0]        readdata,
   input wire logic               waitrequest,
   input wire logic               measEpoch,
   input wire logic               eventInputPin,
   input wire logic [NCH-1:0]     pulseOut,
   input wire logic               eventReportStrobe,
   input wire utc_variant_t       utcVariant
);
   // ********
   // edge tracking since last epoch
   // ********
   logic prevPin;
   logic pend;
   always_ff @(posedge clk) begin
      prevPin <= eventInputPin;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) pend <= 1'b0;
      else if (eventInputPin != prevPin) pend <= 1'b1;
      else if (measEpoch) pend <= 1'b0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_rst_quiet: assert property (disable iff (1'b0) !reset_n |=> waitrequest &&
      pulseOut == '0 && !eventReportStrobe && readdata == '0 && utcVariant == UTC_AUTO)
      else $error("outputs not quiet after reset");
   a_wait_one: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered next cycle");
   a_rdata_cause: assert property ($changed(readdata) |-> $past(read && waitrequest))
      else $error("readdata changed without a read");
   a_unmapped_zero: assert property (read && waitrequest && address == 8'h14 |=> readdata == '0)
      else $error("unmapped read not zero");
   a_strobe_epoch: assert property (eventReportStrobe |-> $past(measEpoch))
      else $error("report strobe without epoch");
   a_strobe_once: assert property (eventReportStrobe |=> !eventReportStrobe)
      else $error("report strobe longer than one cycle");
   a_no_edge_quiet: assert property (measEpoch && !pend && eventInputPin == prevPin
      |=> !eventReportStrobe) else $error("report without edge");
   a_variant_legal: assert property (utcVariant <= UTC_NPLI)
      else $error("illegal utc variant");
   c_strobe: cover property (eventReportStrobe);
   c_pulse: cover property ($rose(pulseOut[0]));
   c_answer: cover property (read && !waitrequest);
endmodule
bind gnss_time_pulse_generator gnss_time_pulse_chk #(.NCH(NCH)) u_chk (.clk(clk),
   .reset_n(reset_n), .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .measEpoch(measEpoch), .eventInputPin(eventInputPin),
   .pulseOut(pulseOut), .eventReportStrobe(eventReportStrobe), .utcVariant(utcVariant));

//--- bench/timing_equipment.sv
// Purpose: far-side timing equipment: event source and pulse watcher
// Assumes: called right after a rising clock edge
// Notes:   marks are whole clock cycles on the selected grid
`timescale 1ns/1ps
module timing_equipment #(
   parameter int unsigned NCH = 2
) (
   input  wire logic           clk,
   input  wire logic [NCH-1:0] pulseIn,
   output      logic           eventPin
);
   initial eventPin = 1'b0;
   // one mark: rise, hold, fall
   task automatic mark(input int hold);
      eventPin <= 1'b1;
      repeat (hold) @(posedge clk);
      eventPin <= 1'b0;
      @(posedge clk);
   endtask
   // active cycles and leading edges over a window
   task automatic watch(input int c, input logic p, input int n, output int act, output int edg);
      logic prev;
      act = 0;
      edg = 0;
      prev = pulseIn[c];
      repeat (n) begin
         @(posedge clk);
         if (pulseIn[c] === p) begin
            act++;
            if (prev !== p) edg++;
         end
         prev = pulseIn[c];
      end
   endtask
endmodule

//--- bench/test_gnss_time_pulse_generator.sv
// Purpose: self-checking bench for the time pulse generator
// Assumes: 20 MHz clock, channel 0 exercised, event stamps on the local time reference
// Notes:   pulse figures counted over 480-cycle windows, the alignment check over 20 cycles
`timescale 1ns/1ps
module test_gnss_time_pulse_generator
   import time_pulse_pkg::*;
;
   typedef struct {
      logic [10:0] ctrl;
      logic [31:0] ru, wu, rl, wl;
      logic        tv, upv;
      int          act, edg;
   } row_t;
   logic clk, reset_n, read, write, waitrequest, timeValid, utcParamsValid;
   logic correctedTick, measEpoch, eventPin, strobe, seen;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, q, r;
   logic [4:0]  tick;
   logic [3:0]  be = 4'hf;
   logic [1:0]  pulseOut;
   utc_variant_t utcVariant;
   int num_errors, total_checks, act, edg;
   row_t rows[11] = '{'{11'h025, 2, 1, 0, 0, 0, 1, 240, 12}, '{11'h021, 2, 25, 0, 0, 0, 1, 120, 12},
      '{11'h025, 2, 5, 0, 0, 0, 1, 480, 0}, '{11'h027, 500000, 1, 0, 0, 0, 1, 240, 12},
      '{11'h035, 2, 1, 4, 1, 1, 1, 120, 6}, '{11'h035, 2, 1, 4, 1, 0, 1, 240, 12},
      '{11'h024, 2, 1, 0, 0, 0, 1, 0, 0}, '{11'h005, 2, 1, 0, 0, 0, 1, 240, 12},
      '{11'h065, 2, 1, 0, 0, 0, 1, 240, 6}, '{11'h025, 2, 1, 0, 0, 0, 0, 0, 0},
      '{11'h125, 2, 1, 0, 0, 0, 0, 240, 12}};
   logic [31:0] uvIn[7] = '{32'h090, 32'h098, 32'h0e8, 32'h0e0, 32'h140, 32'h108, 32'h092};
   utc_variant_t uvExp[7] = '{UTC_EU, UTC_USNO, UTC_SU, UTC_EU, UTC_NTSC, UTC_NPLI, UTC_SU};
   gnss_time_pulse_generator #(.NCH(2)) u_dut (.clk(clk), .reset_n(reset_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(be),
      .readdata(readdata), .waitrequest(waitrequest), .gridSecondTick(tick),
      .timeValid(timeValid), .utcParamsValid(utcParamsValid), .correctedTick(correctedTick),
      .measEpoch(measEpoch), .eventInputPin(eventPin), .pulseOut(pulseOut),
      .eventReportStrobe(strobe), .utcVariant(utcVariant));
   timing_equipment #(.NCH(2)) u_eq (.clk(clk), .pulseIn(pulseOut), .eventPin(eventPin));
   always #25 clk = ~clk;
   always @(posedge clk) correctedTick <= ~correctedTick;
   function automatic logic [7:0] ofs(input logic [4:0] reg_ofs);
      return CH_BASE_OFS + {3'h0, reg_ofs};
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic epoch(output logic s);
      measEpoch <= 1'b1;
      @(posedge clk);
      measEpoch <= 1'b0;
      s = 1'b0;
      repeat (4) begin
         @(posedge clk);
         if (strobe === 1'b1) s = 1'b1;
      end
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      conclude();
   end
   // ********
   // main sequence
   // ********
   initial begin
      {clk, reset_n, read, write, timeValid, correctedTick, measEpoch} = '0;
      {address, writedata, tick} = '0;
      utcParamsValid = 1'b1;
      repeat (5) @(posedge clk);
      chk("wait rst", 1, waitrequest);
      chk("pulse rst", 0, pulseOut);
      chk("variant rst", 0, utcVariant);
      reset_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 11; i++) begin
         timeValid <= rows[i].tv;
         utcParamsValid <= rows[i].upv;
         bus(1, ofs(CH_RATEU_OFS), 0, q);
         repeat (80) @(posedge clk);
         bus(1, ofs(CH_WIDTHU_OFS), rows[i].wu, q);
         bus(1, ofs(CH_RATEL_OFS), rows[i].rl, q);
         bus(1, ofs(CH_WIDTHL_OFS), rows[i].wl, q);
         bus(1, ofs(CH_CTRL_OFS), {21'h0, rows[i].ctrl}, q);
         bus(1, ofs(CH_RATEU_OFS), rows[i].ru, q);
         repeat (240) @(posedge clk);
         u_eq.watch(0, rows[i].ctrl[5], 480, act, edg);
         chk("active", rows[i].act, act);
         chk("edges", rows[i].edg, edg);
      end
      be <= 4'h1;
      bus(1, ofs(CH_DELAY_OFS), 32'h0a0a_0a0a, q);
      be <= 4'hf;
      bus(1, ofs(CH_CTRL_OFS), 32'h12d, q);
      timeValid <= 1'b1;
      tick <= 5'h02;
      @(posedge clk);
      tick <= '0;
      @(posedge clk);
      u_eq.watch(0, 1, 20, act, edg);
      chk("aligned", 10, act);
      for (int i = 0; i < 7; i++) begin
         bus(1, UTC_CTRL_OFS, uvIn[i], q);
         bus(0, UTC_CTRL_OFS, 0, q);
         chk("variant", uvExp[i], utcVariant);
         chk("variant reg", uvExp[i], q[18:16]);
      end
      bus(1, EVT_CTRL_OFS, 32'h0b, q);
      epoch(seen);
      chk("no edge", 0, seen);
      u_eq.mark(3);
      u_eq.mark(7);
      epoch(seen);
      chk("strobe", 1, seen);
      bus(0, EVT_RISE_OFS, 0, r);
      bus(0, EVT_FALL_OFS, 0, q);
      chk("mark span", 7, q - r);
      bus(0, EVT_STAT_OFS, 0, q);
      chk("new flags", 3, q[1:0]);
      bus(1, EVT_CTRL_OFS, 0, q);
      u_eq.mark(2);
      epoch(seen);
      chk("disabled", 0, seen);
      bus(1, EVT_CTRL_OFS, 32'h0b, q);
      epoch(seen);
      chk("stale", 0, seen);
      bus(1, 8'h14, 32'hffff_ffff, q);
      bus(0, 8'h14, 0, q);
      chk("unmapped", 0, q);
      bus(0, ofs(CH_RATEU_OFS), 0, q);
      chk("rate reg", 2, q);
      conclude();
   end
endmodule
